// >>> src/fir_sequencer.sv
// Sequencer that feeds samples, coefficients and controls to one MAC array.
// Assumes the user answers sample_index with sample_value in the same cycle
// and writes coefficients before run is raised.
`timescale 1ns/10ps
module fir_sequencer (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Link to the array
  fir_link_if.sequencer link,
  // Run and mode
  input wire logic run,
  input wire logic multipass,
  input wire logic [fir_pkg::CYC_W-1:0] tap_count,
  input wire fir_pkg::decim_t decim_sel,
  input wire logic coef_signed,
  input wire logic sample_signed,
  input wire logic shift_add,
  // Coefficient write port
  input wire logic coef_wr,
  input wire logic [fir_pkg::TAP_AW-1:0] coef_addr,
  input wire logic [fir_pkg::COEF_W-1:0] coef_data,
  // Sample fetch
  output logic [fir_pkg::INDEX_W-1:0] sample_index,
  input wire logic [fir_pkg::SAMPLE_W-1:0] sample_value,
  // Results
  output logic [fir_pkg::ACC_W-1:0] result_value,
  output logic result_valid
);

  // Whole state of the sequencer
  typedef struct packed {
    logic [fir_pkg::MAX_TAPS-1:0][fir_pkg::COEF_W-1:0] taps; // Coefficient store
    logic [fir_pkg::CYC_W-1:0] cyc;      // Cycle within pass or tap round
    logic [fir_pkg::INDEX_W-1:0] base;   // First sample of the pass
    logic [fir_pkg::INDEX_W-1:0] index;  // Sample being fetched
    logic primed;                        // Streaming: first sum complete
    logic had_pass;                      // Multi-pass: a pass has ended
    logic [fir_pkg::SAMPLE_W-1:0] sample;
    logic [fir_pkg::COEF_W-1:0] coef;
    logic clear;
    logic [fir_pkg::SEL_W-1:0] sel;
    logic shift_add;
    fir_pkg::decim_t decim;
    logic coef_signed;
    logic sample_signed;
    logic [fir_pkg::VPIPE_W-1:0] vpipe;  // Valid readouts in flight
    logic [fir_pkg::ACC_W-1:0] result_value;
    logic result_valid;
  } state_t;

  state_t q; // Current state
  state_t d; // Next state

  // Schedule of coefficients, clears and readouts
  always_comb begin
    logic [fir_pkg::CYC_W-1:0] last_cyc;
    logic [fir_pkg::TAP_AW-1:0] ti;
    last_cyc = tap_count + fir_pkg::CYC_W'(fir_pkg::PASS_ZEROS - 1);
    ti = '0;
    d = q;
    d.clear = 1'b0;
    d.sel = '0;
    d.coef = '0;
    d.shift_add = 1'b0;
    d.decim = decim_sel;
    d.coef_signed = coef_signed;
    d.sample_signed = sample_signed;
    d.vpipe = {q.vpipe[fir_pkg::VPIPE_W-2:0], 1'b0};

    // Coefficient store
    if (coef_wr) begin
      d.taps[coef_addr] = coef_data;
    end

    if (run) begin
      d.sample = sample_value;
      d.shift_add = shift_add;
      if (!multipass) begin
        // Streaming eight taps: last tap first, one cell cleared each clock
        ti = fir_pkg::TAP_AW'(fir_pkg::LAST_SEL) - fir_pkg::TAP_AW'(q.cyc);
        d.coef = q.taps[ti];
        d.clear = 1'b1;
        d.sel = fir_pkg::SEL_W'(q.cyc);
        d.vpipe[0] = q.primed;
        d.index = q.index + 1'b1;
        if (q.cyc == fir_pkg::CYC_W'(fir_pkg::LAST_SEL)) begin
          d.cyc = '0;
          d.primed = 1'b1;
        end else begin
          d.cyc = q.cyc + 1'b1;
        end
      end else begin
        if (q.cyc < tap_count) begin
          // Coefficients in order, last tap first
          ti = fir_pkg::TAP_AW'(tap_count - q.cyc - 1'b1);
          d.coef = q.taps[ti];
          if (q.cyc == '0) begin
            // Last cell's sum of the previous pass is read now
            d.clear = 1'b1;
            d.sel = fir_pkg::LAST_SEL;
            d.vpipe[0] = q.had_pass;
          end
        end else begin
          // Zero coefficients while sums are read and cells cleared
          d.coef = '0;
          d.clear = 1'b1;
          d.sel = fir_pkg::SEL_W'(q.cyc - tap_count);
          d.vpipe[0] = 1'b1;
        end
        if (q.cyc == last_cyc) begin
          // Pass of length plus seven ends; next starts eight samples on
          d.cyc = '0;
          d.base = q.base + fir_pkg::INDEX_W'(fir_pkg::CELLS);
          d.index = q.base + fir_pkg::INDEX_W'(fir_pkg::CELLS);
          d.had_pass = 1'b1;
        end else begin
          d.cyc = q.cyc + 1'b1;
          d.index = q.base + fir_pkg::INDEX_W'(q.cyc) + 1'b1;
        end
      end
    end

    // Capture the bus in the cycle the array drives it
    d.result_valid = q.vpipe[fir_pkg::CAPTURE_TAP];
    if (q.vpipe[fir_pkg::CAPTURE_TAP]) begin
      d.result_value = link.result_bus;
    end
  end

  // State register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Link and user outputs straight from the state register
  assign link.sample = q.sample;
  assign link.coef = q.coef;
  assign link.accum_clear = q.clear;
  assign link.cell_sel = q.sel;
  assign link.shift_add = q.shift_add;
  assign link.decim_sel = q.decim;
  assign link.coef_signed = q.coef_signed;
  assign link.sample_signed = q.sample_signed;
  // Both halves enabled one clock before the readout
  assign link.result_enable_low = q.vpipe[fir_pkg::ENABLE_TAP];
  assign link.result_enable_high = q.vpipe[fir_pkg::ENABLE_TAP];
  assign sample_index = q.index;
  assign result_value = q.result_value;
  assign result_valid = q.result_valid;

endmodule // fir_sequencer

// >>> src/fir_pkg.sv
// Shared constants and types for the eight-cell FIR multiply-accumulate array
// and its sequencer.
// Assumes one system clock and that both ends compile against this package.
package fir_pkg;
  // Array shape
  localparam int CELLS = 8;
  localparam int SEL_W = 3;
  localparam logic [SEL_W-1:0] LAST_SEL = 3'h7;
  // Word widths
  localparam int SAMPLE_W = 8;
  localparam int COEF_W = 8;
  localparam int OPER_W = 9;
  localparam int PROD_W = 18;
  localparam int ACC_W = 26;
  localparam int RESULT_LOW_W = 16;
  // Pipeline: input reg, two multiplier regs, accumulator-side reg
  localparam int PIPELINE_DELAY = 4;
  localparam int CTL_STAGES = PIPELINE_DELAY - 1;
  localparam int VPIPE_W = PIPELINE_DELAY + 1;
  localparam int ENABLE_TAP = PIPELINE_DELAY - 1;
  localparam int CAPTURE_TAP = PIPELINE_DELAY;
  // Output stage shift-and-add distance
  localparam int SHIFT_ADD_BITS = 8;
  // Multi-pass: trailing zero coefficients per pass
  localparam int PASS_ZEROS = 7;
  // Sequencer sizes
  localparam int MAX_TAPS = 64;
  localparam int TAP_AW = 6;
  localparam int CYC_W = 7;
  localparam int INDEX_W = 16;
  // Coefficient hold per cell (decimation by 1, 2 or 3)
  typedef enum logic [1:0] {
    HOLD_ONE = 2'h0,
    HOLD_TWO = 2'h1,
    HOLD_THREE = 2'h2
  } decim_t;
endpackage

// >>> src/fir_link_if.sv
// Link between the FIR MAC array and its sequencer.
// Assumes a single clock; the shared result bus is resolved here from the enables,
// and an undriven half reads as zero, as a pull-down would leave it.
`timescale 1ns/10ps
interface fir_link_if;
  // Sample and coefficient streams
  logic [fir_pkg::SAMPLE_W-1:0] sample;
  logic [fir_pkg::COEF_W-1:0] coef;
  logic [fir_pkg::COEF_W-1:0] coef_out;
  // Accumulator control
  logic accum_clear;
  logic [fir_pkg::SEL_W-1:0] cell_sel;
  logic shift_add;
  // Modes
  fir_pkg::decim_t decim_sel;
  logic coef_signed;
  logic sample_signed;
  // Result bus enables and driver side
  logic result_enable_low;
  logic result_enable_high;
  logic [fir_pkg::ACC_W-1:0] result_data;
  logic result_oe_low;
  logic result_oe_high;
  // Resolved bus level
  wire [fir_pkg::ACC_W-1:0] result_bus;

  // Each half reads zero unless its driver enable is high
  assign result_bus[fir_pkg::RESULT_LOW_W-1:0] =
    result_oe_low ? result_data[fir_pkg::RESULT_LOW_W-1:0] : '0;
  assign result_bus[fir_pkg::ACC_W-1:fir_pkg::RESULT_LOW_W] =
    result_oe_high ? result_data[fir_pkg::ACC_W-1:fir_pkg::RESULT_LOW_W] : '0;

  // Documented device end
  modport device (
    input sample, coef, accum_clear, cell_sel, shift_add,
    input decim_sel, coef_signed, sample_signed,
    input result_enable_low, result_enable_high,
    output coef_out, result_data, result_oe_low, result_oe_high
  );
  // Sequencer end
  modport sequencer (
    output sample, coef, accum_clear, cell_sel, shift_add,
    output decim_sel, coef_signed, sample_signed,
    output result_enable_low, result_enable_high,
    input coef_out, result_bus
  );
endinterface

// >>> src/fir_mac_array.sv
// Eight-cell systolic FIR multiply-accumulate array, device end of the link.
// Assumes the sequencer aligns clear and cell select with the first sample
// of each new sum, and drives the result enables one cycle before it reads.
// Assumes every control on the link comes from a flop on the same clock, so
// nothing here is synchronised.
//
// Timing in brief: a clear for cell c seen at one edge reaches the output
// register three edges later, so the finished sum stands on result_data
// from the fourth cycle after the clear and stays until the next clear.
//
// Notes on behaviour
// - Four register stages from inputs to accumulator.
// - First sum appears length plus four clocks later.
// - One new sum every clock once full.
// - Last sum five clocks after last sample.
// - Output is sum of coefficient times delayed sample.
// - Cascade chains coefficients, shares samples and bus.
// - Cascade clear and enables driven per device.
// - Single device runs passes of seven plus length.
// - Pass feeds its samples, coefficients, seven zeros.
// - Read and clear during trailing zero coefficients.
// - Wide words use shifted added partial products.
// - Three coefficient delays allow hold of 1-3.
// - Coefficients ripple from cell zero; sample broadcast.
// - Eighteen-bit product, twenty-six-bit accumulator per cell.
// - Cells staggered so sums complete on successive clocks.
`timescale 1ns/10ps
module fir_mac_array (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Link to the sequencer
  fir_link_if.device link
);

  // Accumulator control travelling alongside the products
  typedef struct packed {
    logic clear;
    logic [fir_pkg::SEL_W-1:0] sel;
    logic shift_add;
  } ctl_t;

  // Whole state of the array
  typedef struct packed {
    // First coefficient delay of each cell, also its input register
    logic [fir_pkg::CELLS-1:0][fir_pkg::COEF_W-1:0] coef_input_reg;
    // Second and third coefficient delays of each cell
    logic [fir_pkg::CELLS-1:0][fir_pkg::COEF_W-1:0] coef_d2;
    logic [fir_pkg::CELLS-1:0][fir_pkg::COEF_W-1:0] coef_d3;
    // Broadcast sample register
    logic [fir_pkg::SAMPLE_W-1:0] sample_input_reg;
    // Product registers of each cell
    logic [fir_pkg::CELLS-1:0][fir_pkg::PROD_W-1:0] mult_stage_a_reg;
    logic [fir_pkg::CELLS-1:0][fir_pkg::PROD_W-1:0] mult_stage_b_reg;
    // Accumulator-side register of each cell
    logic [fir_pkg::CELLS-1:0][fir_pkg::ACC_W-1:0] accum_feed_reg;
    // Control pipeline, index 0 aligned with the input registers
    ctl_t [fir_pkg::CTL_STAGES-1:0] ctl;
    // Coefficient leaving the last cell
    logic [fir_pkg::COEF_W-1:0] coef_out;
    // Output stage accumulator
    logic [fir_pkg::ACC_W-1:0] result;
    // Registered bus enables
    logic oe_low;
    logic oe_high;
  } state_t;

  state_t q; // Current state
  state_t d; // Next state

  // Coefficient seen at a cell's output for the chosen hold
  function automatic logic [fir_pkg::COEF_W-1:0] hold_pick(
    input fir_pkg::decim_t mode,
    input logic [fir_pkg::COEF_W-1:0] one,
    input logic [fir_pkg::COEF_W-1:0] two,
    input logic [fir_pkg::COEF_W-1:0] three
  );
    logic [fir_pkg::COEF_W-1:0] pick;
    pick = one;
    case (mode)
      // Pass after one clock
      fir_pkg::HOLD_ONE: begin
        pick = one;
      end
      // Hold two clocks per cell
      fir_pkg::HOLD_TWO: begin
        pick = two;
      end
      // Hold three clocks per cell
      fir_pkg::HOLD_THREE: begin
        pick = three;
      end
      // Unused code acts as no hold
      default: begin
        pick = one;
      end
    endcase
    return pick;
  endfunction

  // Next-state logic for every cell and the output stage.
  // The multiplier sees the first coefficient delay of its cell whatever the
  // hold, so decimation only changes how fast coefficients walk the chain.
  // The accumulator-side register is the accumulator itself; the output stage
  // reads it in the same edge in which a clear restarts it, so the old sum is
  // taken before it is lost and no extra holding register is needed.
  // Operands are nine bits so that unsigned and two's complement words share
  // one signed multiplier; an unsigned product never reaches bit 17.
  always_comb begin
    logic [fir_pkg::COEF_W-1:0] cin;
    logic signed [fir_pkg::OPER_W-1:0] c_op;
    logic signed [fir_pkg::OPER_W-1:0] s_op;
    logic [fir_pkg::ACC_W-1:0] ext;
    logic [fir_pkg::ACC_W-1:0] picked;
    logic [fir_pkg::ACC_W-1:0] shifted;
    ctl_t c;
    logic tc;
    cin = link.coef;
    c_op = '0;
    s_op = '0;
    ext = '0;
    picked = '0;
    shifted = '0;
    c = q.ctl[fir_pkg::CTL_STAGES-1];
    tc = link.coef_signed | link.sample_signed;
    d = q;

    // Stage one: sample broadcast to all cells at once
    d.sample_input_reg = link.sample;

    // Stage one control, then carried along with the products
    d.ctl[0] = '{clear: link.accum_clear, sel: link.cell_sel, shift_add: link.shift_add};
    for (int k = 1; k < fir_pkg::CTL_STAGES; k++) begin
      d.ctl[k] = q.ctl[k-1];
    end

    for (int i = 0; i < fir_pkg::CELLS; i++) begin
      // Coefficient shifts through three delays; cell zero takes the input
      if (i == fir_pkg::CELLS - 1) begin
        // Matches the last cell's output one clock ahead, so no extra lag
        d.coef_out = hold_pick(link.decim_sel, cin, q.coef_input_reg[i], q.coef_d2[i]);
      end
      d.coef_input_reg[i] = cin;
      d.coef_d2[i] = q.coef_input_reg[i];
      d.coef_d3[i] = q.coef_d2[i];
      // Next cell is fed from the selected delay
      cin = hold_pick(link.decim_sel, q.coef_input_reg[i], q.coef_d2[i], q.coef_d3[i]);

      // Operands extended by sign or by zero as the mode asks
      c_op = {link.coef_signed & q.coef_input_reg[i][fir_pkg::COEF_W-1], q.coef_input_reg[i]};
      s_op = {link.sample_signed & q.sample_input_reg[fir_pkg::SAMPLE_W-1],
              q.sample_input_reg};
      // Stages two and three: 18-bit product
      d.mult_stage_a_reg[i] = fir_pkg::PROD_W'(c_op) * fir_pkg::PROD_W'(s_op);
      d.mult_stage_b_reg[i] = q.mult_stage_a_reg[i];

      // Stage four: product widened into the 26-bit accumulator
      ext = {{(fir_pkg::ACC_W - fir_pkg::PROD_W){q.mult_stage_b_reg[i][fir_pkg::PROD_W-1]}},
             q.mult_stage_b_reg[i]};
      if (c.clear && (c.sel == fir_pkg::SEL_W'(i))) begin
        // Cleared cell starts a new sum with this product only
        d.accum_feed_reg[i] = ext;
      end else begin
        // Other cells keep summing coefficient times sample
        d.accum_feed_reg[i] = q.accum_feed_reg[i] + ext;
      end
    end

    // Output stage takes the finished sum of the cleared cell
    // With no clear the output register holds, so a reader that comes late
    // still sees the last sum; shift-add chains rely on that held value.
    if (c.clear) begin
      picked = q.accum_feed_reg[c.sel];
      if (tc) begin
        shifted = fir_pkg::ACC_W'($signed(q.result) >>> fir_pkg::SHIFT_ADD_BITS);
      end else begin
        shifted = q.result >> fir_pkg::SHIFT_ADD_BITS;
      end
      if (c.shift_add) begin
        // Partial product added to the previous one moved down eight bits
        d.result = picked + shifted;
      end else begin
        // Plain readout of the finished sum
        d.result = picked;
      end
    end

    // Bus halves follow their enables one clock later
    // Registering them keeps the drive from glitching with the enable lines.
    d.oe_low = link.result_enable_low;
    d.oe_high = link.result_enable_high;
  end

  // State register.
  // Reset clears every delay line, so the first sums after reset only see
  // zero coefficients from before the release.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Link outputs come straight from the state register.
  // The drive enables leave this block as flops; the bus itself is resolved
  // in the link so several arrays may share it in a cascade.
  assign link.coef_out = q.coef_out;
  assign link.result_data = q.result;
  assign link.result_oe_low = q.oe_low;
  assign link.result_oe_high = q.oe_high;

endmodule // fir_mac_array

// >>> testbench/fir_link_properties.sv
// Concurrent checks on the link between the FIR array and its sequencer.
// Assumes one clock; every input other than clk and nrst is a plain copy of a link signal.
`timescale 1ns/10ps
module fir_link_properties (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Coefficient path
  input wire logic [7:0] coef,
  input wire logic [7:0] coef_out,
  input wire fir_pkg::decim_t decim_sel,
  // Accumulator control
  input wire logic accum_clear,
  input wire logic [2:0] cell_sel,
  // Result bus
  input wire logic result_enable_low,
  input wire logic result_enable_high,
  input wire logic [25:0] result_data,
  input wire logic result_oe_low,
  input wire logic result_oe_high
);
  // Cycles since the hold mode last changed, saturating
  logic [4:0] age_q;

  // Age counter clears on a mode change so stale delay lines are not judged
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      age_q <= 5'h0;
    end else if (decim_sel != $past(decim_sel)) begin
      age_q <= 5'h0;
    end else if (age_q != 5'h1F) begin
      age_q <= age_q + 5'h1;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  AST_OE_LOW: assert property (result_oe_low |-> $past(result_enable_low))
    else $error("low half driven without its enable");
  AST_OE_HIGH: assert property (result_oe_high |-> $past(result_enable_high))
    else $error("high half driven without its enable");
  AST_READ_CLEAR: assert property ((result_enable_low || result_enable_high) |-> $past(accum_clear, 3))
    else $error("read enable not three cycles after a clear");
  AST_RESULT_STANDS: assert property (!$past(accum_clear, 4) |-> $stable(result_data))
    else $error("result changed with no clear four cycles back");
  AST_CELL_ORDER: assert property (accum_clear && $past(accum_clear) |-> cell_sel == $past(cell_sel) + 3'h1)
    else $error("back to back clears not on successive cells");
  AST_HOLD_ONE: assert property (decim_sel == fir_pkg::HOLD_ONE && age_q > 5'h9 |-> coef_out == $past(coef, 8))
    else $error("coefficient chain delay wrong for hold one");
  AST_HOLD_TWO: assert property (decim_sel == fir_pkg::HOLD_TWO && age_q > 5'h11 |-> coef_out == $past(coef, 16))
    else $error("coefficient chain delay wrong for hold two");
  AST_HOLD_THREE: assert property (decim_sel == fir_pkg::HOLD_THREE && age_q > 5'h19 |-> coef_out == $past(coef, 24))
    else $error("coefficient chain delay wrong for hold three");

  // Main scenarios reached
  COV_CLEAR: cover property (accum_clear);
  COV_READ: cover property (result_oe_low && result_oe_high);
  COV_HOLD3: cover property (decim_sel == fir_pkg::HOLD_THREE && age_q == 5'h1F);
endmodule // fir_link_properties

// >>> testbench/eight_cell_fir_mac_array_tb_top.sv
// Bench joining the FIR array and its sequencer through the link.
// Assumes package, link interface, both design ends and checker compile first.
`timescale 1ns/10ps
module eight_cell_fir_mac_array_tb_top;
  // Clock, reset and sequencer user side
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic run = 1'b0, multipass = 1'b0, coef_signed = 1'b0, sample_signed = 1'b0;
  logic shift_add = 1'b0, coef_wr = 1'b0;
  logic [6:0] tap_count = 7'h8;
  fir_pkg::decim_t decim_sel = fir_pkg::HOLD_ONE;
  logic [5:0] coef_addr = 6'h0;
  logic [7:0] coef_data = 8'h0;
  logic [15:0] sample_index;
  logic [7:0] sample_value;
  logic [25:0] result_value;
  logic result_valid;
  logic [7:0] tap [64];
  int err_count = 0, n_checks = 0;

  // 20 MHz clock
  always #25 clk = ~clk;

  fir_link_if link ();
  fir_mac_array u_fir_mac_array (.clk, .nrst, .link(link.device));
  fir_sequencer u_fir_sequencer (.clk, .nrst, .link(link.sequencer), .run, .multipass,
    .tap_count, .decim_sel, .coef_signed, .sample_signed, .shift_add, .coef_wr, .coef_addr,
    .coef_data, .sample_index, .sample_value, .result_value, .result_valid);
  fir_link_properties u_fir_link_properties (.clk, .nrst, .coef(link.coef),
    .coef_out(link.coef_out), .decim_sel(link.decim_sel), .accum_clear(link.accum_clear),
    .cell_sel(link.cell_sel), .result_enable_low(link.result_enable_low),
    .result_enable_high(link.result_enable_high), .result_data(link.result_data),
    .result_oe_low(link.result_oe_low), .result_oe_high(link.result_oe_high));

  // Sample stream, answered in the cycle it is asked for
  function automatic logic [7:0] xv(input int n);
    return 8'(n * 37 + 11);
  endfunction
  assign sample_value = xv(int'(sample_index));

  // Reference sum of products for output n of an l-tap filter
  function automatic logic [25:0] yv(input int n, input int l);
    logic signed [25:0] s;
    logic signed [9:0] a;
    logic signed [9:0] b;
    logic [7:0] x;
    s = '0;
    for (int k = 0; k < l; k++) begin
      x = xv(n - k);
      a = {{2{coef_signed & tap[k][7]}}, tap[k]};
      b = {{2{sample_signed & x[7]}}, x};
      s = s + a * b;
    end
    return s;
  endfunction

  // Compare and count
  task automatic chk(input logic [25:0] e, input logic [25:0] g);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("Error at %0t: expected %h got %h", $time, e, g);
    end
  endtask

  // Pulse reset for n cycles, also in mid-run
  task automatic do_reset(input int n);
    @(negedge clk);
    nrst = 1'b0;
    run = 1'b0;
    repeat (n) @(negedge clk);
    nrst = 1'b1;
  endtask

  // Write taps 0..l-1 with a ramp of step m
  task automatic load(input int l, input int m);
    for (int k = 0; k < l; k++) begin
      tap[k] = 8'(k * m + 3);
      coef_addr = 6'(k);
      coef_data = tap[k];
      coef_wr = 1'b1;
      @(negedge clk);
    end
    coef_wr = 1'b0;
  endtask

  // Run the schedule and judge nres results in order
  task automatic go(input logic mp, input int l, input int nres, input int id);
    int n, cyc;
    logic [25:0] last;
    logic [25:0] e;
    n = l - 1;
    cyc = 0;
    last = '0;
    multipass = mp;
    tap_count = 7'(l);
    run = 1'b1;
    while (n < l - 1 + nres && cyc < 300) begin
      @(negedge clk);
      if (result_valid === 1'b1) begin
        if (n == l - 1) chk(26'(l + fir_pkg::PIPELINE_DELAY + 1), 26'(cyc));
        e = yv(n, l) + (shift_add && n > l - 1 ? last >> 8 : 26'h0);
        if (!(shift_add && n == l - 1)) chk(e, result_value);
        last = result_value;
        n++;
      end else if (!mp && n > l - 1) chk(26'h1, 26'(result_valid));
      cyc++;
    end
    run = 1'b0;
    chk(26'(l - 1 + nres), 26'(n));
    $display("Test %0d done at %0t", id, $time);
  endtask

  // Closing report and verdict
  task automatic wrap_up;
    $display("Checks %0d, mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (12) @(negedge clk);
    nrst = 1'b1;
    chk(26'h0, link.result_bus);
    chk(26'h0, 26'({link.result_oe_high, link.result_oe_low}));
    load(8, 5);
    go(1'b0, 8, 24, 1);
    do_reset(2);
    coef_signed = 1'b1;
    sample_signed = 1'b1;
    load(8, 41);
    go(1'b0, 8, 16, 2);
    do_reset(2);
    coef_signed = 1'b0;
    sample_signed = 1'b0;
    shift_add = 1'b1;
    load(8, 41);
    go(1'b0, 8, 16, 3);
    shift_add = 1'b0;
    do_reset(2);
    load(16, 7);
    go(1'b1, 16, 24, 4);
    do_reset(2);
    load(9, 29);
    go(1'b1, 9, 16, 5);
    do_reset(2);
    load(8, 5);
    multipass = 1'b0;
    decim_sel = fir_pkg::HOLD_TWO;
    run = 1'b1;
    repeat (40) @(negedge clk);
    decim_sel = fir_pkg::HOLD_THREE;
    repeat (40) @(negedge clk);
    do_reset(1);
    decim_sel = fir_pkg::HOLD_ONE;
    chk(26'h0, link.result_bus);
    chk(26'h0, 26'({link.result_oe_high, link.result_oe_low}));
    $display("Test 6 done at %0t", $time);
    wrap_up();
  end

  // Watchdog sized well above the expected run of about 370 cycles
  initial begin
    #(4000 * 50);
    err_count++;
    wrap_up();
  end
endmodule // eight_cell_fir_mac_array_tb_top
